// file: inc/epwm_pkg.sv
// Purpose: shared constants of the eight channel pwm timer
// Assumes: 32-bit ahb-lite register bus, one word per register
// Notes: channel cores are built 16 bits wide so pairs can join
package epwm_pkg;
  localparam int unsigned NCH = 8;
  localparam int unsigned NPAIR = 4;
  localparam int unsigned CH_W = 8;
  localparam int unsigned CORE_W = 16;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PER_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_DUTY_BASE = 8'h40;
  localparam int unsigned CTRL_EN_LSB = 0;
  localparam int unsigned CTRL_POL_LSB = 8;
  localparam int unsigned CTRL_CTR_LSB = 16;
  localparam int unsigned CTRL_CAT_LSB = 24;
  localparam int unsigned CTRL_W = 28;
  localparam logic [CTRL_W-1:0] CTRL_RST = 28'h000_FF00;
  localparam logic [CH_W-1:0] MODE_RST = 8'h00;
  localparam logic [CH_W-1:0] PER_RST = 8'hFF;
  localparam logic [CH_W-1:0] DUTY_RST = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;
  localparam logic HRESP_OKAY = 1'b0;
endpackage : epwm_pkg

// file: inc/epwm_if.sv
// Purpose: carriers between the pwm top, its bus slave and channel cores
// Assumes: single clock domain
// Notes: cfg side drives settings, core side returns the pin level
interface epwm_ch_if #(parameter int unsigned W = 16);
  logic en;
  logic pol;
  logic center;
  logic pcm;
  logic [W-1:0] per;
  logic [W-1:0] duty;
  logic out;
  modport cfg (output en, pol, center, pcm, per, duty, input out);
  modport core (input en, pol, center, pcm, per, duty, output out);
endinterface : epwm_ch_if

interface epwm_bus_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport slave (output wr_en, rd_en, addr, wdata, input rdata);
  modport regs (input wr_en, rd_en, addr, wdata, output rdata);
endinterface : epwm_bus_if

// file: src/epwm_ahb_slave.sv
// Purpose: ahb-lite slave front end for the pwm register file
// Assumes: single word transfers, hready fed back from hreadyout
// Notes: writes take no wait state, reads take one
module epwm_ahb_slave (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  epwm_bus_if.slave bus
);
  import epwm_pkg::*;
  logic ph_valid_reg, ph_valid_next;
  logic ph_write_reg, ph_write_next;
  logic [ADDR_W-1:0] ph_addr_reg, ph_addr_next;
  logic rd_wait_reg, rd_wait_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic take;

  always_comb begin
    take = i_hsel && i_htrans == HTRANS_NONSEQ && i_hsize == HSIZE_WORD && i_hready;
    ph_valid_next = ph_valid_reg;
    ph_write_next = ph_write_reg;
    ph_addr_next = ph_addr_reg;
    if (i_hready) begin
      ph_valid_next = take;
      ph_write_next = i_hwrite;
      ph_addr_next = i_haddr[ADDR_W-1:0];
    end
    rd_wait_next = bus.rd_en;
    hrdata_next = bus.rd_en ? bus.rdata : hrdata_reg;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg <= '0;
      rd_wait_reg <= 1'b0;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      ph_valid_reg <= ph_valid_next;
      ph_write_reg <= ph_write_next;
      ph_addr_reg <= ph_addr_next;
      rd_wait_reg <= rd_wait_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // read data is fetched in the first data cycle, handed out in the second
  assign bus.rd_en = ph_valid_reg && !ph_write_reg && !rd_wait_reg;
  assign bus.wr_en = ph_valid_reg && ph_write_reg;
  assign bus.addr = ph_addr_reg;
  assign bus.wdata = i_hwdata;
  assign o_hreadyout = !bus.rd_en;
  assign o_hrdata = hrdata_reg;
endmodule : epwm_ahb_slave

// file: src/epwm_chan.sv
// Purpose: one pwm channel core with counter, shadow settings and pin level
// Assumes: settings from the register file, same clock
// Notes: pcm mode ignores centre alignment
module epwm_chan #(parameter int unsigned W = 16) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  epwm_ch_if.core ch
);
  logic [W-1:0] cnt_reg, cnt_next;
  logic dir_reg, dir_next;
  logic [W-1:0] acc_reg, acc_next;
  logic [W-1:0] per_act_reg, per_act_next;
  logic [W-1:0] duty_act_reg, duty_act_next;
  logic out_reg, out_next;
  logic period_end;
  logic active;
  logic full;
  logic [W:0] acc_sum;

  always_comb begin
    cnt_next = cnt_reg;
    dir_next = dir_reg;
    acc_next = acc_reg;
    per_act_next = per_act_reg;
    duty_act_next = duty_act_reg;
    period_end = 1'b0;
    active = 1'b0;
    full = duty_act_reg >= per_act_reg;
    acc_sum = {1'b0, acc_reg} + {1'b0, duty_act_reg};
    if (!ch.en) begin
      cnt_next = '0;
      dir_next = 1'b0;
      acc_next = '0;
      period_end = 1'b1;
    end else if (ch.center && !ch.pcm) begin
      active = cnt_reg < duty_act_reg;
      if (per_act_reg == '0) begin
        period_end = 1'b1;
      end else if (!dir_reg) begin
        if (cnt_reg >= per_act_reg) begin
          dir_next = 1'b1;
          cnt_next = cnt_reg - 1'b1;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end else if (cnt_reg <= W'(1)) begin
        cnt_next = '0;
        dir_next = 1'b0;
        period_end = 1'b1;
      end else begin
        cnt_next = cnt_reg - 1'b1;
      end
    end else begin
      dir_next = 1'b0;
      if (ch.pcm) begin
        active = (duty_act_reg != '0) && (full || acc_sum >= {1'b0, per_act_reg});
        if (!full) begin
          acc_next = active ? W'(acc_sum - {1'b0, per_act_reg}) : acc_sum[W-1:0];
        end
      end else begin
        active = cnt_reg < duty_act_reg;
      end
      if (({1'b0, cnt_reg} + 1'b1) >= {1'b0, per_act_reg}) begin
        cnt_next = '0;
        acc_next = '0;
        period_end = 1'b1;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
    if (period_end) begin
      per_act_next = ch.per;
      duty_act_next = ch.duty;
    end
    out_next = (ch.en && active) ? ch.pol : !ch.pol;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= '0;
      dir_reg <= 1'b0;
      acc_reg <= '0;
      per_act_reg <= '0;
      duty_act_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      dir_reg <= dir_next;
      acc_reg <= acc_next;
      per_act_reg <= per_act_next;
      duty_act_reg <= duty_act_next;
      out_reg <= out_next;
    end
  end

  assign ch.out = out_reg;

  sequence s_peak;
    ch.en && ch.center && !ch.pcm && per_act_reg != '0 && !dir_reg && cnt_reg >= per_act_reg;
  endsequence

  a_zero_duty_idle: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    ch.en && duty_act_reg == '0 |=> out_reg == !$past(ch.pol))
    else $error("zero duty drove the active level");
  a_pcm_spread: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    ch.en && ch.pcm && active && !period_end && ({duty_act_reg, 1'b0} <= {1'b0, per_act_reg})
    |=> !(ch.en && ch.pcm && active))
    else $error("pcm gave two active cycles in a row at low duty");
  a_pol_idle: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !ch.en |=> out_reg == !$past(ch.pol))
    else $error("disabled channel not at inactive level");
  a_center_turn: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_peak |=> dir_reg && cnt_reg == $past(cnt_reg) - 1'b1)
    else $error("centre counter did not turn down at the peak");
  a_left_up: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    ch.en && !ch.center && ch.en |=> !dir_reg && (cnt_reg == $past(cnt_reg) + 1'b1 || cnt_reg == '0))
    else $error("left aligned counter did not count up or wrap");
  a_shadow_hold: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    ch.en && !period_end |=> $stable(per_act_reg) && $stable(duty_act_reg))
    else $error("settings changed inside a period");
endmodule : epwm_chan

// file: src/epwm_top.sv
// Purpose: eight channel 8-bit pwm timer with ahb-lite register access
// Assumes: single word transfers, hready fed back from hreadyout
// Notes: joined pairs drive the odd pin, even pin rests at its inactive level
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
module epwm_top (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [epwm_pkg::NCH-1:0] o_pwm
);
  import epwm_pkg::*;

  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [CH_W-1:0] mode_reg, mode_next;
  logic [CH_W-1:0] per_reg [NCH];
  logic [CH_W-1:0] per_next [NCH];
  logic [CH_W-1:0] duty_reg [NCH];
  logic [CH_W-1:0] duty_next [NCH];
  logic [NCH-1:0] ctrl_en;
  logic [NCH-1:0] ctrl_pol;
  logic [NCH-1:0] ctrl_center;
  logic [NPAIR-1:0] ctrl_cat;
  logic [2:0] reg_idx;
  logic is_per;
  logic is_duty;
  logic [31:0] rdata;

  epwm_bus_if bus ();
  epwm_ch_if #(.W(CORE_W)) chan [NCH] ();

  epwm_ahb_slave u_slave (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hsize(i_hsize),
    .i_hwdata(i_hwdata),
    .i_hready(i_hready),
    .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout),
    .bus(bus.slave)
  );

  assign o_hresp = HRESP_OKAY;

  assign ctrl_en = ctrl_reg[CTRL_EN_LSB +: NCH];
  assign ctrl_pol = ctrl_reg[CTRL_POL_LSB +: NCH];
  assign ctrl_center = ctrl_reg[CTRL_CTR_LSB +: NCH];
  assign ctrl_cat = ctrl_reg[CTRL_CAT_LSB +: NPAIR];

  // address decode shared by writes and reads
  assign reg_idx = bus.addr[4:2];
  assign is_per = bus.addr[7:5] == OFF_PER_BASE[7:5] && bus.addr[1:0] == 2'b00;
  assign is_duty = bus.addr[7:5] == OFF_DUTY_BASE[7:5] && bus.addr[1:0] == 2'b00;

  // register writes, unmapped addresses are ignored
  always_comb begin
    ctrl_next = ctrl_reg;
    mode_next = mode_reg;
    per_next = per_reg;
    duty_next = duty_reg;
    if (bus.wr_en) begin
      if (bus.addr == OFF_CTRL) begin
        ctrl_next = bus.wdata[CTRL_W-1:0];
      end
      if (bus.addr == OFF_MODE) begin
        mode_next = bus.wdata[CH_W-1:0];
      end
      if (is_per) begin
        per_next[reg_idx] = bus.wdata[CH_W-1:0];
      end
      if (is_duty) begin
        duty_next[reg_idx] = bus.wdata[CH_W-1:0];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_reg <= CTRL_RST;
      mode_reg <= MODE_RST;
      for (int k = 0; k < NCH; k++) begin
        per_reg[k] <= PER_RST;
        duty_reg[k] <= DUTY_RST;
      end
    end else begin
      ctrl_reg <= ctrl_next;
      mode_reg <= mode_next;
      per_reg <= per_next;
      duty_reg <= duty_next;
    end
  end

  // read mux, unmapped addresses read as zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (bus.addr == OFF_CTRL) begin
      rdata[CTRL_W-1:0] = ctrl_reg;
    end else if (bus.addr == OFF_MODE) begin
      rdata[CH_W-1:0] = mode_reg;
    end else if (bus.addr == OFF_STAT) begin
      rdata[NCH-1:0] = o_pwm;
    end else if (is_per) begin
      rdata[CH_W-1:0] = per_reg[reg_idx];
    end else if (is_duty) begin
      rdata[CH_W-1:0] = duty_reg[reg_idx];
    end
  end

  assign bus.rdata = rdata;

  // one core per channel, odd core takes the whole pair when joined
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    if (i % 2 == 1) begin : g_odd
      assign chan[i].en = ctrl_en[i];
      assign chan[i].per = ctrl_cat[i/2] ? {per_reg[i], per_reg[i-1]} : {8'h00, per_reg[i]};
      assign chan[i].duty = ctrl_cat[i/2] ? {duty_reg[i], duty_reg[i-1]} : {8'h00, duty_reg[i]};
    end else begin : g_even
      assign chan[i].en = ctrl_en[i] && !ctrl_cat[i/2];
      assign chan[i].per = {8'h00, per_reg[i]};
      assign chan[i].duty = {8'h00, duty_reg[i]};
    end
    assign chan[i].pol = ctrl_pol[i];
    assign chan[i].center = ctrl_center[i];
    assign chan[i].pcm = mode_reg[i];
    assign o_pwm[i] = chan[i].out;

    epwm_chan #(.W(CORE_W)) u_chan (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .ch(chan[i].core)
    );
  end

  sequence s_rd_req;
    i_hsel && i_htrans == HTRANS_NONSEQ && i_hsize == HSIZE_WORD && !i_hwrite && i_hready;
  endsequence

  sequence s_rd_answer;
    !o_hreadyout ##1 o_hreadyout;
  endsequence

  sequence s_wr_per0;
    i_hsel && i_htrans == HTRANS_NONSEQ && i_hsize == HSIZE_WORD && i_hwrite && i_hready
      && i_haddr[ADDR_W-1:0] == OFF_PER_BASE;
  endsequence

  sequence s_pair0_joined;
    ctrl_cat[0] [*2];
  endsequence

  a_read_wait: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_rd_req |=> s_rd_answer)
    else $error("read answer not after exactly one wait cycle");
  a_resp_okay: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_hresp == HRESP_OKAY && (!bus.wr_en || o_hreadyout))
    else $error("slave gave other than okay or stalled a write");
  a_narrow_read: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_rd_req ##0 (i_haddr[ADDR_W-1:0] == OFF_PER_BASE) |=> ##1 o_hrdata[31:CH_W] == 24'h00_0000
      && o_hrdata[CH_W-1:0] == per_reg[0])
    else $error("period read back wider than 8 bits or wrong");
  a_per_private: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_wr_per0 |=> ##1 per_reg[0] == $past(i_hwdata[CH_W-1:0]) && $stable(per_reg[1])
      && $stable(duty_reg[0]))
    else $error("period write did not land in its own channel only");
  a_pair_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_pair0_joined |-> o_pwm[0] == !$past(ctrl_pol[0]))
    else $error("even pin of a joined pair left its inactive level");
  a_pair_wide: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    ctrl_cat[0] |-> chan[1].per[15:8] == per_reg[1] && chan[1].per[7:0] == per_reg[0])
    else $error("joined pair period not formed from both halves");

  // write side: zero wait, data lands one edge after the data phase
  sequence s_wr_req;
    i_hsel && i_htrans == HTRANS_NONSEQ && i_hsize == HSIZE_WORD && i_hwrite && i_hready;
  endsequence

  sequence s_wr_ctrl;
    s_wr_req ##0 i_haddr[ADDR_W-1:0] == OFF_CTRL;
  endsequence

  sequence s_wr_mode;
    s_wr_req ##0 i_haddr[ADDR_W-1:0] == OFF_MODE;
  endsequence

  sequence s_wr_duty0;
    s_wr_req ##0 i_haddr[ADDR_W-1:0] == OFF_DUTY_BASE;
  endsequence

  sequence s_rd_ctrl;
    s_rd_req ##0 i_haddr[ADDR_W-1:0] == OFF_CTRL;
  endsequence

  sequence s_rd_stat;
    s_rd_req ##0 i_haddr[ADDR_W-1:0] == OFF_STAT;
  endsequence

  a_write_nowait: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_wr_req |=> o_hreadyout)
    else $error("write data phase was stalled");
  a_ctrl_lands: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_wr_ctrl |=> ##1 ctrl_reg == $past(i_hwdata[CTRL_W-1:0]))
    else $error("control write did not land");
  a_mode_lands: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_wr_mode |=> ##1 mode_reg == $past(i_hwdata[CH_W-1:0]) && $stable(ctrl_reg))
    else $error("mode write did not land or disturbed control");
  a_duty_private: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_wr_duty0 |=> ##1 duty_reg[0] == $past(i_hwdata[CH_W-1:0]) && $stable(duty_reg[1])
      && $stable(per_reg[0]))
    else $error("duty write did not land in its own channel only");
  a_quiet_bus: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !bus.wr_en |=> $stable(ctrl_reg) && $stable(mode_reg))
    else $error("settings moved without a bus write");

  // read side: one fetch, no write, data held until the next read
  a_read_no_write: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_rd_req |=> !bus.wr_en ##1 !bus.wr_en)
    else $error("read data phase raised a register write");
  a_fetch_once: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    bus.rd_en |=> !bus.rd_en)
    else $error("one read fetched twice");
  a_hrdata_hold: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !bus.rd_en |=> $stable(o_hrdata))
    else $error("read data changed without a read");
  a_ctrl_readback: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_rd_ctrl |=> ##1 o_hrdata[CTRL_W-1:0] == $past(ctrl_reg) && o_hrdata[31:CTRL_W] == '0)
    else $error("control read back wrong");
  a_stat_live: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_rd_stat |=> ##1 o_hrdata[NCH-1:0] == $past(o_pwm) && o_hrdata[31:NCH] == '0)
    else $error("status read did not show the pins");

  // per channel register access and idle level
  for (genvar i = 0; i < NCH; i++) begin : g_chk
    sequence s_rd_per;
      s_rd_req ##0 i_haddr[ADDR_W-1:0] == OFF_PER_BASE + ADDR_W'(4 * i);
    endsequence

    sequence s_rd_duty;
      s_rd_req ##0 i_haddr[ADDR_W-1:0] == OFF_DUTY_BASE + ADDR_W'(4 * i);
    endsequence

    sequence s_wr_per;
      s_wr_req ##0 i_haddr[ADDR_W-1:0] == OFF_PER_BASE + ADDR_W'(4 * i);
    endsequence

    sequence s_wr_duty;
      s_wr_req ##0 i_haddr[ADDR_W-1:0] == OFF_DUTY_BASE + ADDR_W'(4 * i);
    endsequence

    a_per_readback: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      s_rd_per |=> ##1 o_hrdata[CH_W-1:0] == $past(per_reg[i]) && o_hrdata[31:CH_W] == '0)
      else $error("period read back wrong or wider than 8 bits");
    a_duty_readback: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      s_rd_duty |=> ##1 o_hrdata[CH_W-1:0] == $past(duty_reg[i]) && o_hrdata[31:CH_W] == '0)
      else $error("duty read back wrong or wider than 8 bits");
    a_per_lands: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      s_wr_per |=> ##1 per_reg[i] == $past(i_hwdata[CH_W-1:0]))
      else $error("period write did not land");
    a_duty_lands: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      s_wr_duty |=> ##1 duty_reg[i] == $past(i_hwdata[CH_W-1:0]))
      else $error("duty write did not land");
    a_off_inactive: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      !chan[i].en |=> o_pwm[i] == !$past(ctrl_pol[i]))
      else $error("disabled pin left its inactive level");
  end

  // joined pairs: odd core sees both halves, even pin rests
  for (genvar p = 0; p < NPAIR; p++) begin : g_pair_chk
    sequence s_joined;
      ctrl_cat[p] [*2];
    endsequence

    a_join_rest: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      s_joined |-> o_pwm[2*p] == !$past(ctrl_pol[2*p]))
      else $error("even pin of a joined pair left its inactive level");
    a_join_halves: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      ctrl_cat[p] |-> chan[2*p+1].per == {per_reg[2*p+1], per_reg[2*p]}
        && chan[2*p+1].duty == {duty_reg[2*p+1], duty_reg[2*p]})
      else $error("joined pair settings not formed from both halves");
    a_split_narrow: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      !ctrl_cat[p] |-> chan[2*p+1].per[CORE_W-1:CH_W] == '0 && chan[2*p+1].duty[CORE_W-1:CH_W] == '0)
      else $error("unjoined channel saw more than 8 bits");
  end
endmodule : epwm_top

// file: test/epwm_load.sv
// Purpose: model of the loads hanging on the eight pwm pins
// Assumes: pins are plain levels sampled on the system clock
// Notes: counts active-high cycles and rising edges per pin until cleared
module epwm_load (
  input wire logic i_ref_clk,
  input wire logic i_clr,
  input wire logic [epwm_pkg::NCH-1:0] i_pwm,
  output logic [15:0] o_hi [epwm_pkg::NCH],
  output logic [15:0] o_rise [epwm_pkg::NCH]
);
  timeunit 1ns;
  timeprecision 100ps;
  import epwm_pkg::*;
  logic [NCH-1:0] prev;

  always @(posedge i_ref_clk) begin
    prev <= i_pwm;
    for (int i = 0; i < NCH; i++) begin
      if (i_clr) begin
        o_hi[i] <= 16'h0000;
        o_rise[i] <= 16'h0000;
      end else begin
        o_hi[i] <= o_hi[i] + 16'(i_pwm[i]);
        o_rise[i] <= o_rise[i] + 16'(i_pwm[i] & ~prev[i]);
      end
    end
  end
endmodule : epwm_load

// file: test/epwm_top_bench.sv
// Purpose: self-checking bench of the eight channel pwm timer
// Assumes: one ahb-lite master, hready fed back from hreadyout
// Notes: pin waveforms judged through the load model over whole periods
module epwm_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import epwm_pkg::*;
  logic clk;
  logic nrst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [NCH-1:0] pwm;
  logic clr;
  logic [15:0] hi [NCH];
  logic [15:0] rise [NCH];
  int n_fail = 0;
  int n_checks = 0;

  epwm_top DUT (.i_ref_clk(clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .o_pwm(pwm));
  epwm_load LOAD (.i_ref_clk(clk), .i_clr(clr), .i_pwm(pwm), .o_hi(hi), .o_rise(rise));

  task print_verdict;
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wait_rdy(output logic [31:0] q);
    int k;
    logic r;
    k = 0;
    r = 1'b0;
    while (r !== 1'b1) begin
      @(negedge clk);
      r = hready;
      q = hrdata;
      @(posedge clk);
      k++;
      if (k > 40) begin
        n_fail++;
        print_verdict();
      end
    end
  endtask : wait_rdy

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    wait_rdy(q);
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy(q);
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask : rd

  task automatic cfg(input int ch, input logic [7:0] p, input logic [7:0] d);
    wr(OFF_PER_BASE + 8'(4 * ch), {24'h00_0000, p});
    wr(OFF_DUTY_BASE + 8'(4 * ch), {24'h00_0000, d});
  endtask : cfg

  task automatic meas(input int n);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : meas

  task automatic t_reset;
    chk("pins", 32'h0000_0000, {24'h00_0000, pwm});
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
    rd("ctrl", OFF_CTRL, {4'h0, CTRL_RST});
    rd("mode", OFF_MODE, {24'h00_0000, MODE_RST});
    rd("per7", OFF_PER_BASE + 8'h1C, {24'h00_0000, PER_RST});
    rd("duty0", OFF_DUTY_BASE, {24'h00_0000, DUTY_RST});
    rd("stat", OFF_STAT, 32'h0000_0000);
    wr(8'h10, 32'hFFFF_FFFF);
    rd("unmapped", 8'h10, 32'h0000_0000);
  endtask : t_reset

  task automatic t_mix;
    int pe [NCH] = '{4, 5, 3, 4, 3, 4, 4, 6};
    int du [NCH] = '{1, 2, 0, 1, 2, 2, 2, 6};
    int eh [NCH] = '{15, 24, 0, 45, 30, 30, 30, 60};
    int er [NCH] = '{15, 12, 0, 15, 10, 30, 15, 0};
    for (int i = 0; i < NCH; i++) begin
      cfg(i, 8'(pe[i]), 8'(du[i]));
    end
    rd("per1", OFF_PER_BASE + 8'h04, 32'h0000_0005);
    rd("per0", OFF_PER_BASE, 32'h0000_0004);
    wr(OFF_MODE, 32'h0000_0020);
    wr(OFF_CTRL, 32'h0010_F7FF);
    repeat (60) @(posedge clk);
    meas(60);
    for (int i = 0; i < NCH; i++) begin
      chk($sformatf("hi%0d", i), 32'(eh[i]), {16'h0000, hi[i]});
      chk($sformatf("rise%0d", i), 32'(er[i]), {16'h0000, rise[i]});
    end
    @(posedge clk);
  endtask : t_mix

  task automatic t_join;
    wr(OFF_CTRL, 32'h0000_0000);
    cfg(0, 8'h04, 8'h82);
    cfg(1, 8'h01, 8'h00);
    wr(OFF_CTRL, 32'h0100_FF03);
    repeat (300) @(posedge clk);
    meas(520);
    chk("join_hi", 32'h0000_0104, {16'h0000, hi[1]});
    chk("join_even", 32'h0000_0000, {16'h0000, hi[0]});
    @(posedge clk);
  endtask : t_join

  task automatic t_update;
    int run;
    logic st;
    wr(OFF_CTRL, 32'h0000_0000);
    cfg(0, 8'h08, 8'h06);
    wr(OFF_CTRL, 32'h0000_FF01);
    repeat (19) @(posedge clk);
    run = 0;
    st = 1'b0;
    fork
      wr(OFF_DUTY_BASE, 32'h0000_0002);
      for (int j = 0; j < 64; j++) begin
        @(negedge clk);
        if (pwm[0] === 1'b1 && st) begin
          run++;
        end else if (pwm[0] !== 1'b1) begin
          if (run != 0) chk("pulse_len", 32'h0000_0001, 32'(run == 2 || run == 6));
          run = 0;
          st = 1'b1;
        end
      end
    join
    @(posedge clk);
    meas(16);
    chk("new_duty", 32'h0000_0004, {16'h0000, hi[0]});
    @(posedge clk);
  endtask : t_update

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0000_0000;
    clr = 1'b1;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_mix();
    t_join();
    t_update();
    print_verdict();
  end
endmodule : epwm_top_bench
